// ===== logic/usb_host_pipe_transfer_ctrl.sv
// Purpose: Host pipe sequencing, bank handshake and pipe interrupts
// Assumes: All inputs on core_clk; link engine does the bus signalling
// Notes:   BANKS must be two or more
// Behaviour
// - Control pipe: SETUP starts with DATA0, IN and OUT with DATA1.
// - Counted mode issues request count plus one IN requests, then freezes.
// - Endless mode keeps issuing IN requests while the pipe is unfrozen.
// - Configure and pick mode first; requests start only when unfrozen.
// - IN bank full sets received flag and ownership flag together.
// - Received-IN clear touches only the received flag.
// - IN ownership clear frees bank, switches, reloads flags from next bank.
// - IN read allowed while current bank holds unread data.
// - OUT bank free sets transmitted flag and ownership flag together.
// - Transmitted-OUT clear touches only the transmitted flag.
// - OUT ownership clear hands bank over, switches, reloads flags.
// - OUT write allowed while current bank has room.
// - Suspend with an OUT bank ready resumes itself and sends it.
// - Isochronous IN CRC failure sets the CRC flag.
// - A CRC-failed packet is stored and flagged received as usual.
// - Global sources are all processing, none exception.
// - Pipe sources split into processing and exception groups.
// - DMA sources are all processing.
// - Frame generation disabled means suspend and no frame starts.
`timescale 1ns/10ps
module usb_host_pipe_transfer_ctrl
  import usb_pipe_pkg::*;
#(
  parameter int BANKS = BANK_NUM,
  parameter int WORDS = BANK_WORDS
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire usb_pipe_pkg::pipe_cfg_t   cfg,
  input  wire logic                      tokenLoad,
  input  wire logic                      freezeSet,
  input  wire logic                      freezeClear,
  input  wire logic [usb_pipe_pkg::NFLAG-1:0]   flagEn,
  input  wire logic [usb_pipe_pkg::NFLAG-1:0]   flagClear,
  input  wire logic [usb_pipe_pkg::NFLAG-1:0]   extFlagSet,
  input  wire logic [usb_pipe_pkg::NGLOBAL-1:0] globalFlags,
  input  wire logic [usb_pipe_pkg::NDMA-1:0]    dmaFlags,
  input  wire logic                      bankOwnershipClear,
  input  wire logic                      sofEnableWr,
  input  wire logic                      sofEnableVal,
  input  wire logic                      sofTick,
  input  wire logic                      swWrValid,
  input  wire logic [usb_pipe_pkg::DATA_W-1:0]  swWrData,
  output logic                           swWrReady,
  output logic                           swRdValid,
  output logic [usb_pipe_pkg::DATA_W-1:0]       swRdData,
  input  wire logic                      swRdReady,
  input  wire logic                      rxValid,
  input  wire usb_pipe_pkg::word_t       rxWord,
  output logic                           rxReady,
  input  wire logic                      linkNoData,
  output logic                           txValid,
  output usb_pipe_pkg::word_t            txWord,
  input  wire logic                      txReady,
  output logic                           inRequest,
  output logic                           dataToggle,
  output logic                           sofPulse,
  output logic                           pipeFreeze,
  output logic [usb_pipe_pkg::NFLAG-1:0]        pipeFlags,
  output logic                           bankOwnership,
  output logic                           readWriteAllowed,
  output logic                           pipeIrq,
  output logic                           pipeExcIrq,
  output logic                           hostIrq,
  output logic                           hostExcIrq,
  output logic                           frameGenEnable,
  output logic                           suspended
);
  import usb_pipe_pkg::*;

  localparam int BB = $clog2(BANKS);
  localparam int PW = $clog2(WORDS + 1);
  localparam int AW = $clog2(BANKS * WORDS);
  localparam logic [PW-1:0] FULL_CNT = PW'(WORDS);

  function automatic logic [BB-1:0] nextBank(input logic [BB-1:0] b);
    nextBank = (b == BB'(BANKS - 1)) ? '0 : b + 1'b1;
  endfunction

  function automatic logic [AW-1:0] addrOf(input logic [BB-1:0] b,
                                          input logic [PW-1:0] p);
    addrOf = AW'(int'(b) * WORDS + int'(p));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] mem [BANKS*WORDS];
  logic              memWe;
  logic [AW-1:0]     memAddr;
  logic [DATA_W-1:0] memWd;

  state_t            state_r,    state_nxt;
  logic [BB-1:0]     swBank_r,   swBank_nxt;
  logic [BB-1:0]     hwBank_r,   hwBank_nxt;
  logic [PW-1:0]     swPtr_r,    swPtr_nxt;
  logic [PW-1:0]     hwPtr_r,    hwPtr_nxt;
  logic [PW-1:0]     cnt_r [BANKS];
  logic [PW-1:0]     cnt_nxt [BANKS];
  logic [BANKS-1:0]  full_r,     full_nxt;
  logic [NFLAG-1:0]  flags_r,    flags_nxt;
  logic              bank_ownership_flag_r,  bank_ownership_flag_nxt;
  logic              freeze_r,   freeze_nxt;
  logic [REQ_W-1:0]  reqLeft_r,  reqLeft_nxt;
  logic              toggle_r,   toggle_nxt;
  logic              frame_generation_enable_r,     frame_generation_enable_nxt;
  logic              sofP_r,     sofP_nxt;
  logic              inReq_r,    inReq_nxt;
  logic              rxRdy_r,    rxRdy_nxt;
  word_t             buf_r [2];
  word_t             buf_nxt [2];
  logic [1:0]        bufCnt_r,   bufCnt_nxt;
  logic              txV_r,      txV_nxt;
  word_t             txW_r,      txW_nxt;
  logic              rdV_r,      rdV_nxt;
  logic [DATA_W-1:0] rdD_r,      rdD_nxt;
  logic              wrRdy_r,    wrRdy_nxt;
  logic              read_write_allowed_r,    read_write_allowed_nxt;
  logic              irq_r,      irq_nxt;
  logic              exc_r,      exc_nxt;
  logic              hIrq_r,     hIrq_nxt;
  logic              hExc_r,     hExc_nxt;
  logic              susp_r,     susp_nxt;

  logic isIn, isOut, issueReq, startTx, pop, push, outReady, rxDone;
  logic [BB-1:0] nb;

  assign isIn     = cfg.token == TOK_IN;
  assign isOut    = cfg.token == TOK_OUT;
  // Requests only from an unfrozen pipe with a free bank
  assign issueReq = state_r == ST_IDLE && isIn && !freeze_r && frame_generation_enable_r &&
                    !full_r[hwBank_r];
  assign outReady = isOut && !freeze_r && full_r[hwBank_r];
  assign startTx  = state_r == ST_IDLE && outReady && frame_generation_enable_r;
  assign pop      = state_r == ST_WAIT && bufCnt_r != 2'h0 && !linkNoData;
  assign push     = rxValid && rxRdy_r;
  assign rxDone   = pop && buf_r[0].last;
  assign nb       = nextBank(swBank_r);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt   = state_r;
    swBank_nxt  = swBank_r;
    hwBank_nxt  = hwBank_r;
    swPtr_nxt   = swPtr_r;
    hwPtr_nxt   = hwPtr_r;
    cnt_nxt     = cnt_r;
    full_nxt    = full_r;
    flags_nxt   = flags_r & ~flagClear;
    bank_ownership_flag_nxt = bank_ownership_flag_r;
    freeze_nxt  = freeze_r;
    reqLeft_nxt = reqLeft_r;
    toggle_nxt  = toggle_r;
    frame_generation_enable_nxt    = frame_generation_enable_r;
    inReq_nxt   = 1'b0;
    txV_nxt     = txV_r;
    txW_nxt     = txW_r;
    rdV_nxt     = rdV_r;
    rdD_nxt     = rdD_r;
    memWe       = 1'b0;
    memAddr     = '0;
    memWd       = '0;
    if (tokenLoad && cfg.isCtrl) begin
      toggle_nxt = (cfg.token == TOK_SETUP) ? TOGGLE_SETUP : TOGGLE_DATA;
    end
    if (freezeClear) begin
      freeze_nxt  = 1'b0;
      reqLeft_nxt = REQ_W'(cfg.inCount) + REQ_ONE;
      if (isOut && !full_r[swBank_r]) begin
        bank_ownership_flag_nxt        = 1'b1;
        flags_nxt[F_TXOUT] = 1'b1;
      end
    end
    if (freezeSet) begin
      freeze_nxt = 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (issueReq) begin
          state_nxt = ST_WAIT;
          inReq_nxt = 1'b1;
          hwPtr_nxt = '0;
          if (!cfg.in_request_mode) begin
            reqLeft_nxt = reqLeft_r - REQ_ONE;
            if (reqLeft_r == REQ_ONE) begin
              freeze_nxt = 1'b1;
            end
          end
        end else if (startTx) begin
          state_nxt = ST_TX;
          hwPtr_nxt = '0;
        end
      end
      ST_WAIT: begin
        if (linkNoData) begin
          state_nxt = ST_IDLE;
        end else if (pop) begin
          if (hwPtr_r < FULL_CNT) begin
            memWe     = 1'b1;
            memAddr   = addrOf(hwBank_r, hwPtr_r);
            memWd     = buf_r[0].data;
            hwPtr_nxt = hwPtr_r + 1'b1;
          end else begin
            flags_nxt[F_OVER] = 1'b1;
          end
          if (buf_r[0].last) begin
            cnt_nxt[hwBank_r]  = hwPtr_nxt;
            full_nxt[hwBank_r] = 1'b1;
            hwBank_nxt         = nextBank(hwBank_r);
            state_nxt          = ST_IDLE;
            if (buf_r[0].crcErr && cfg.isIso) begin
              flags_nxt[F_CRC] = 1'b1;
            end else if (!buf_r[0].crcErr) begin
              toggle_nxt = !toggle_r;
            end
            if (hwBank_r == swBank_r) begin
              flags_nxt[F_RXIN] = 1'b1;
              bank_ownership_flag_nxt       = 1'b1;
            end
          end
        end
      end
      ST_TX: begin
        if (!txV_r || txReady) begin
          if (hwPtr_r < cnt_r[hwBank_r]) begin
            txV_nxt        = 1'b1;
            txW_nxt.data   = mem[addrOf(hwBank_r, hwPtr_r)];
            txW_nxt.last   = hwPtr_r == cnt_r[hwBank_r] - 1'b1;
            txW_nxt.crcErr = 1'b0;
            hwPtr_nxt      = hwPtr_r + 1'b1;
          end else begin
            txV_nxt            = 1'b0;
            full_nxt[hwBank_r] = 1'b0;
            cnt_nxt[hwBank_r]  = '0;
            hwBank_nxt         = nextBank(hwBank_r);
            state_nxt          = ST_IDLE;
            toggle_nxt         = !toggle_r;
            if (hwBank_r == swBank_r) begin
              flags_nxt[F_TXOUT] = 1'b1;
              bank_ownership_flag_nxt        = 1'b1;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (bankOwnershipClear && bank_ownership_flag_r) begin
      swBank_nxt = nb;
      swPtr_nxt  = '0;
      rdV_nxt    = 1'b0;
      if (isIn) begin
        full_nxt[swBank_r] = 1'b0;
        cnt_nxt[swBank_r]  = '0;
        bank_ownership_flag_nxt        = full_nxt[nb];
        flags_nxt[F_RXIN]  = full_nxt[nb] | extFlagSet[F_RXIN];
      end else begin
        full_nxt[swBank_r] = 1'b1;
        cnt_nxt[swBank_r]  = swPtr_r;
        bank_ownership_flag_nxt        = !full_nxt[nb];
        flags_nxt[F_TXOUT] = !full_nxt[nb] | extFlagSet[F_TXOUT];
      end
    end else if (isIn) begin
      if (!rdV_r || swRdReady) begin
        rdV_nxt = 1'b0;
        if (bank_ownership_flag_r && swPtr_r < cnt_r[swBank_r]) begin
          rdV_nxt   = 1'b1;
          rdD_nxt   = mem[addrOf(swBank_r, swPtr_r)];
          swPtr_nxt = swPtr_r + 1'b1;
        end
      end
    end else if (isOut && swWrValid && wrRdy_r) begin
      memWe     = 1'b1;
      memAddr   = addrOf(swBank_r, swPtr_r);
      memWd     = swWrData;
      swPtr_nxt = swPtr_r + 1'b1;
    end
    wrRdy_nxt = isOut && bank_ownership_flag_nxt && swPtr_nxt < FULL_CNT;
    if (isIn) begin
      read_write_allowed_nxt = rdV_nxt ||
                  (bank_ownership_flag_nxt && swPtr_nxt < cnt_nxt[swBank_nxt]);
    end else begin
      read_write_allowed_nxt = wrRdy_nxt;
    end
    if (sofEnableWr) begin
      frame_generation_enable_nxt = sofEnableVal;
    end
    if (!frame_generation_enable_r && outReady) begin
      frame_generation_enable_nxt = 1'b1;
    end
    sofP_nxt  = sofTick && frame_generation_enable_r;
    susp_nxt  = !frame_generation_enable_nxt;
    flags_nxt = flags_nxt | extFlagSet;
    irq_nxt   = |(flags_nxt & flagEn);
    exc_nxt   = |(flags_nxt & flagEn & PIPE_EXC_MASK);
    hIrq_nxt  = irq_nxt | (|globalFlags) | (|dmaFlags);
    hExc_nxt  = (|(globalFlags & GLOBAL_EXC_MASK)) |
                (|(dmaFlags & DMA_EXC_MASK));
  end

  // Two-entry skid buffer on the receive path
  always_comb begin
    buf_nxt    = buf_r;
    bufCnt_nxt = bufCnt_r;
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      bufCnt_nxt = bufCnt_r - 1'b1;
    end
    if (push) begin
      buf_nxt[bufCnt_nxt[0]] = rxWord;
      bufCnt_nxt             = bufCnt_nxt + 1'b1;
    end
    rxRdy_nxt = bufCnt_nxt < SKID_DEPTH;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mem[memAddr] <= memWd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      swBank_r <= '0;
      hwBank_r <= '0;
      swPtr_r  <= '0;
      hwPtr_r  <= '0;
      cnt_r    <= '{default: '0};
      full_r   <= '0;
      flags_r  <= '0;
      bank_ownership_flag_r <= 1'b0;
      freeze_r <= 1'b1;
      reqLeft_r <= '0;
      toggle_r <= TOGGLE_SETUP;
      frame_generation_enable_r   <= 1'b0;
      sofP_r   <= 1'b0;
      inReq_r  <= 1'b0;
      rxRdy_r  <= 1'b0;
      buf_r    <= '{default: '0};
      bufCnt_r <= '0;
      txV_r    <= 1'b0;
      txW_r    <= '0;
      rdV_r    <= 1'b0;
      rdD_r    <= '0;
      wrRdy_r  <= 1'b0;
      read_write_allowed_r  <= 1'b0;
      irq_r    <= 1'b0;
      exc_r    <= 1'b0;
      hIrq_r   <= 1'b0;
      hExc_r   <= 1'b0;
      susp_r   <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      swBank_r <= swBank_nxt;
      hwBank_r <= hwBank_nxt;
      swPtr_r  <= swPtr_nxt;
      hwPtr_r  <= hwPtr_nxt;
      cnt_r    <= cnt_nxt;
      full_r   <= full_nxt;
      flags_r  <= flags_nxt;
      bank_ownership_flag_r <= bank_ownership_flag_nxt;
      freeze_r <= freeze_nxt;
      reqLeft_r <= reqLeft_nxt;
      toggle_r <= toggle_nxt;
      frame_generation_enable_r   <= frame_generation_enable_nxt;
      sofP_r   <= sofP_nxt;
      inReq_r  <= inReq_nxt;
      rxRdy_r  <= rxRdy_nxt;
      buf_r    <= buf_nxt;
      bufCnt_r <= bufCnt_nxt;
      txV_r    <= txV_nxt;
      txW_r    <= txW_nxt;
      rdV_r    <= rdV_nxt;
      rdD_r    <= rdD_nxt;
      wrRdy_r  <= wrRdy_nxt;
      read_write_allowed_r  <= read_write_allowed_nxt;
      irq_r    <= irq_nxt;
      exc_r    <= exc_nxt;
      hIrq_r   <= hIrq_nxt;
      hExc_r   <= hExc_nxt;
      susp_r   <= susp_nxt;
    end
  end

  assign swWrReady        = wrRdy_r;
  assign swRdValid        = rdV_r;
  assign swRdData         = rdD_r;
  assign rxReady          = rxRdy_r;
  assign txValid          = txV_r;
  assign txWord           = txW_r;
  assign inRequest        = inReq_r;
  assign dataToggle       = toggle_r;
  assign sofPulse         = sofP_r;
  assign pipeFreeze       = freeze_r;
  assign pipeFlags        = flags_r;
  assign bankOwnership    = bank_ownership_flag_r;
  assign readWriteAllowed = read_write_allowed_r;
  assign pipeIrq          = irq_r;
  assign pipeExcIrq       = exc_r;
  assign hostIrq          = hIrq_r;
  assign hostExcIrq       = hExc_r;
  assign frameGenEnable   = frame_generation_enable_r;
  assign suspended        = susp_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_setup_toggle;
    tokenLoad && cfg.isCtrl && cfg.token == TOK_SETUP && !rxDone
      && state_r != ST_TX |=> !toggle_r;
  endproperty
  a_setup_toggle: assert property (p_setup_toggle)
    else $error("setup toggle not data0");
  property p_data_toggle;
    tokenLoad && cfg.isCtrl && cfg.token != TOK_SETUP && !rxDone
      && state_r != ST_TX |=> toggle_r;
  endproperty
  a_data_toggle: assert property (p_data_toggle)
    else $error("data stage toggle not data1");
  property p_count_freeze;
    issueReq && !cfg.in_request_mode && reqLeft_r == REQ_ONE |=> freeze_r;
  endproperty
  a_count_freeze: assert property (p_count_freeze)
    else $error("pipe not frozen after last request");
  property p_endless;
    issueReq && cfg.in_request_mode && !freezeSet |=> !freeze_r ##0 inRequest;
  endproperty
  a_endless: assert property (p_endless)
    else $error("endless mode froze pipe");
  property p_frozen_quiet;
    freeze_r |=> !inRequest;
  endproperty
  a_frozen_quiet: assert property (p_frozen_quiet)
    else $error("request from frozen pipe");
  property p_rx_pair;
    $rose(flags_r[F_RXIN]) && isIn && !$past(extFlagSet[F_RXIN])
      |-> bank_ownership_flag_r;
  endproperty
  a_rx_pair: assert property (p_rx_pair)
    else $error("received flag without ownership");
  property p_rx_clear;
    flagClear[F_RXIN] && !extFlagSet[F_RXIN] && !rxDone
      && !bankOwnershipClear |=> !flags_r[F_RXIN] && $stable(bank_ownership_flag_r);
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("received clear misbehaved");
  property p_irq;
    1'b1 |=> pipeIrq == |(flags_r & $past(flagEn));
  endproperty
  a_irq: assert property (p_irq)
    else $error("pipe interrupt mismatch");
  property p_no_sof;
    !frame_generation_enable_r |=> !sofPulse;
  endproperty
  a_no_sof: assert property (p_no_sof)
    else $error("frame start while suspended");
  property p_auto_resume;
    !frame_generation_enable_r && outReady |=> frame_generation_enable_r;
  endproperty
  a_auto_resume: assert property (p_auto_resume)
    else $error("no resume with out bank ready");
  property p_crc;
    rxDone && buf_r[0].crcErr && cfg.isIso |=> flags_r[F_CRC];
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc flag not set");

  c_in_done: cover property (rxDone ##[1:20] bankOwnershipClear);
  c_tx_done: cover property (txValid && txWord.last && txReady);
  c_resume:  cover property (!frame_generation_enable_r && outReady ##1 frame_generation_enable_r);
endmodule

// ===== logic/usb_pipe_pkg.sv
// Purpose: Shared types and constants for the host pipe transfer logic
// Assumes: One pipe, one clock, software and link on that clock
// Notes:   Flag index order is the pipe status vector order
package usb_pipe_pkg;
  localparam int DATA_W     = 8;
  localparam int BANK_NUM   = 2;
  localparam int BANK_WORDS = 8;
  localparam int REQ_W      = 9;
  localparam int NFLAG      = 11;
  localparam int NGLOBAL    = 9;
  localparam int NDMA       = 3;
  // Pipe flags: processing first, exceptions from underflow upward
  localparam int F_RXIN  = 0;
  localparam int F_TXOUT = 1;
  localparam int F_TXSTP = 2;
  localparam int F_SHORT = 3;
  localparam int F_NBUSY = 4;
  localparam int F_UNDER = 5;
  localparam int F_PERR  = 6;
  localparam int F_NAK   = 7;
  localparam int F_OVER  = 8;
  localparam int F_STALL = 9;
  localparam int F_CRC   = 10;
  localparam logic [NFLAG-1:0]   PIPE_EXC_MASK   = 11'h7E0;
  // Global: connect, disconnect, reset sent, resume sent,
  // upstream resume, frame start, wake-up, pipe, dma channel
  localparam logic [NGLOBAL-1:0] GLOBAL_EXC_MASK = 9'h000;
  // Dma: end of transfer, end of buffer, descriptor loaded
  localparam logic [NDMA-1:0]    DMA_EXC_MASK    = 3'h0;
  localparam logic               TOGGLE_SETUP    = 1'b0;
  localparam logic               TOGGLE_DATA     = 1'b1;
  localparam logic [REQ_W-1:0]   REQ_ONE         = 9'h001;
  localparam logic [1:0]         SKID_DEPTH      = 2'h2;

  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN    = 2'h1,
    TOK_OUT   = 2'h2
  } token_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_TX   = 3'h4
  } state_t;

  typedef struct packed {
    logic               isCtrl;
    logic               isIso;
    token_t             token;
    logic               in_request_mode;
    logic [REQ_W-2:0]   inCount;
  } pipe_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic               last;
    logic               crcErr;
  } word_t;
endpackage

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the host pipe transfer logic
// Assumes: Default bank count and size
// Notes:   Read and sent words are checked from queues
`timescale 1ns/10ps
module testbench;
  import usb_pipe_pkg::*;
  logic core_clk = 0, rst_b = 0, tokenLoad = 0, freezeSet = 0;
  logic freezeClear = 0, bankOwnershipClear = 0, sofEnableWr = 0;
  logic sofEnableVal = 0, sofTick = 0, swWrValid = 0, swRdReady = 0;
  logic sendPkt = 0, badCrc = 0;
  pipe_cfg_t cfg = '0;
  logic [NFLAG-1:0] flagEn = '0, flagClear = '0, extFlagSet = '0, pipeFlags;
  logic [NGLOBAL-1:0] globalFlags = '0;
  logic [NDMA-1:0] dmaFlags = '0;
  logic [7:0] swWrData = '0, swRdData;
  word_t rxWord, txWord;
  logic swWrReady, swRdValid, rxValid, rxReady, linkNoData, txValid;
  logic txReady, inRequest, dataToggle, sofPulse, pipeFreeze;
  logic bankOwnership, readWriteAllowed, pipeIrq, pipeExcIrq;
  logic hostIrq, hostExcIrq, frameGenEnable, suspended;
  int mismatches = 0, checks = 0, reqs = 0, sofs = 0;
  logic [15:0] lfsr = 16'h365B;
  logic [7:0] rdQ[$], txQ[$];

  usb_host_pipe_transfer_ctrl dut_u (.*);
  usb_dev_model dev_u (.*);

  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic bit cond(input int k);
    case (k)
      0: return pipeFlags[F_RXIN] === 1'b1;
      1: return pipeFlags[F_TXOUT] === 1'b1;
      2: return rdQ.size() == 0;
      3: return txQ.size() == 0;
      default: return swWrReady === 1'b1;
    endcase
  endfunction
  task automatic waitFor(input int k);
    int n;
    for (n = 0; n < 300 && !cond(k); n++)
      tick();
    if (n == 300) begin
      mismatches++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (swRdValid && swRdReady)
      check(swRdData, rdQ.size() ? rdQ.pop_front() : 8'hXX, "read");
    if (txValid && txReady)
      check(txWord.data, txQ.size() ? txQ.pop_front() : 8'hXX, "sent");
    if (inRequest)
      reqs++;
    if (sofPulse)
      sofs++;
  end

  initial begin
    tick(10);
    rst_b = 1;
    tick();
    check(pipeFreeze, 1, "freeze");
    check(suspended, 1, "suspend");
    check(pipeFlags, 0, "flags");
    cfg.isCtrl = 1;
    for (int t = 0; t < 3; t++) begin
      cfg.token = token_t'(t);
      tokenLoad = 1;
      tick();
      tokenLoad = 0;
      tick();
      check(dataToggle, t ? TOGGLE_DATA : TOGGLE_SETUP, "toggle");
    end
    cfg = '0;
    cfg.inCount = 8'h02;
    cfg.token = TOK_IN;
    sofEnableWr = 1;
    sofEnableVal = 1;
    tick();
    sofEnableWr = 0;
    sofTick = 1;
    tick();
    sofTick = 0;
    tick(20);
    check(sofs, 1, "frames on");
    check(reqs, 0, "frozen requests");
    freezeClear = 1;
    tick();
    freezeClear = 0;
    tick(100);
    check(reqs, 3, "counted requests");
    check(pipeFreeze, 1, "count freeze");
    cfg.in_request_mode = 1;
    reqs = 0;
    freezeClear = 1;
    tick();
    freezeClear = 0;
    tick(100);
    check(reqs > 10, 1, "endless requests");
    check(pipeFreeze, 0, "endless freeze");
    freezeSet = 1;
    tick();
    freezeSet = 0;
    tick(5);
    reqs = 0;
    tick(20);
    check(reqs, 0, "refrozen requests");
    cfg = '0;
    cfg.isIso = 1;
    cfg.token = TOK_IN;
    sendPkt = 1;
    badCrc = 1;
    flagEn[F_RXIN] = 1;
    freezeClear = 1;
    tick();
    freezeClear = 0;
    waitFor(0);
    check(bankOwnership, 1, "in owner");
    check(pipeFlags[F_CRC], 1, "crc flag");
    check(pipeIrq, 1, "in irq");
    tick(2);
    check(readWriteAllowed, 1, "in allowed");
    flagClear[F_RXIN] = 1;
    tick();
    flagClear = '0;
    tick();
    check(pipeFlags[F_RXIN], 0, "rx clear");
    check(bankOwnership, 1, "rx clear owner");
    check(pipeIrq, 0, "irq drop");
    rdQ = '{8'hC2, 8'hC1};
    swRdReady = 1;
    waitFor(2);
    swRdReady = 0;
    tick(2);
    check(readWriteAllowed, 0, "in empty");
    bankOwnershipClear = 1;
    tick();
    bankOwnershipClear = 0;
    tick(2);
    check(bankOwnership, 0, "in release");
    flagClear = '1;
    flagEn[F_NAK] = 1;
    extFlagSet[F_NAK] = 1;
    tick();
    flagClear = '0;
    extFlagSet = '0;
    tick(2);
    check(pipeExcIrq, 1, "exception irq");
    lfsr = lfsrNext(lfsr);
    globalFlags = lfsr[8:0] | 9'h001;
    dmaFlags = 3'h4;
    tick(2);
    check(hostIrq, 1, "host irq");
    check(hostExcIrq, 0, "host exc");
    flagEn = '0;
    tick(2);
    check(hostIrq, 1, "host irq global");
    sofEnableWr = 1;
    sofEnableVal = 1;
    cfg = '0;
    cfg.token = TOK_OUT;
    flagEn[F_TXOUT] = 1;
    tick();
    sofEnableWr = 0;
    freezeClear = 1;
    tick();
    freezeClear = 0;
    waitFor(1);
    check(bankOwnership, 1, "out owner");
    flagClear[F_TXOUT] = 1;
    tick();
    flagClear = '0;
    tick();
    check({pipeFlags[F_TXOUT], bankOwnership}, 1, "tx clear");
    check(readWriteAllowed, 1, "out room");
    swWrValid = 1;
    for (int i = 0; i < BANK_WORDS; i++) begin
      lfsr = lfsrNext(lfsr);
      swWrData = lfsr[7:0];
      txQ.push_back(lfsr[7:0]);
      waitFor(4);
      tick();
    end
    swWrValid = 0;
    tick();
    check(readWriteAllowed, 0, "out full");
    bankOwnershipClear = 1;
    tick();
    bankOwnershipClear = 0;
    sofEnableWr = 1;
    sofEnableVal = 0;
    tick();
    sofEnableWr = 0;
    tick(4);
    check(frameGenEnable, 1, "auto resume");
    check({pipeFlags[F_TXOUT], bankOwnership}, 3, "next bank");
    waitFor(3);
    sofEnableWr = 1;
    tick();
    sofEnableWr = 0;
    sofs = 0;
    repeat (5) begin
      sofTick = 1;
      tick();
      sofTick = 0;
      tick();
    end
    check(sofs, 0, "no frames");
    check(suspended, 1, "suspend");
    conclude();
  end
endmodule

// ===== testbench/usb_dev_model.sv
// Purpose: Attached device answering IN requests and taking OUT words
// Assumes: Everything on core_clk rising edge
// Notes:   Data lines show a changing pattern while no word is offered
`timescale 1ns/10ps
module usb_dev_model
  import usb_pipe_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           inRequest,
  input  wire logic           sendPkt,
  input  wire logic           badCrc,
  output logic                rxValid,
  output usb_pipe_pkg::word_t rxWord,
  input  wire logic           rxReady,
  output logic                linkNoData,
  output logic                txReady
);
  logic [1:0] left = 2'h0;
  logic [7:0] junk = 8'h5A;
  initial linkNoData = 1'b0;
  initial txReady = 1'b0;
  // Two-word packet C2, C1; the word holds until taken
  assign rxValid = left != 2'h0;
  assign rxWord = rxValid ? {8'hC0 + {6'h0, left}, left == 2'h1, badCrc}
                          : {junk, 2'h0};
  always @(posedge core_clk) begin
    linkNoData <= inRequest && !sendPkt;
    txReady <= !txReady;
    junk <= ~junk;
    if (inRequest && sendPkt)
      left <= 2'h2;
    else if (rxValid && rxReady)
      left <= left - 2'h1;
  end
endmodule
